/* File: inc/lacb_pkg.sv */
// constants and types shared by the logic-and-carry-branch execute block
package lacb_pkg;
   localparam int unsigned INSTR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BANK_W = 4;
   localparam int unsigned ADDR_W = BANK_W + DATA_W;
   // opcode fields
   localparam int unsigned OPC_HI_POS = 12;
   localparam int unsigned OPC_MID_POS = 8;
   localparam int unsigned DEST_POS = 9;
   localparam int unsigned ACCESS_POS = 8;
   localparam logic [3:0] OPC_IMM_HI = 4'h0;
   localparam logic [3:0] OPC_IMM_MID = 4'hb;
   localparam logic [3:0] OPC_REG_HI = 4'h1;
   localparam logic [1:0] OPC_REG_MID = 2'h1;
   localparam logic [3:0] OPC_BR_HI = 4'he;
   localparam logic [3:0] OPC_BR_MID = 4'h2;
   // destination and access bit values
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic ACCESS_FIXED = 1'b0;
   localparam logic ACCESS_BANKED = 1'b1;
   // access bank split and indexed-offset limit
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   // program counter step per instruction word
   localparam int unsigned PC_STEP = 2;
   // reset values
   // all ones, so that AND results can be seen without a load instruction
   localparam logic [7:0] ACC_RST = 8'hff;
   localparam logic FLAG_RST = 1'b0;
   // cycle figures
   localparam int unsigned BR_TAKEN_CYCLES = 2;
   localparam int unsigned BR_IDLE_CYCLES = BR_TAKEN_CYCLES - 1;
   typedef enum logic [0:0]
   {
      ST_EXEC = 1'b0,
      ST_IDLE = 1'b1
   } lacb_state_t;
endpackage

/* File: inc/lacb_addr_if.sv */
// carries a file operand address request and its resolved physical address
`timescale 1ns/10ps
`default_nettype none
interface lacb_addr_if;
   import lacb_pkg::*;
   logic [7:0] file_addr;
   logic access_bit;
   logic ext_set_en;
   logic [BANK_W-1:0] bank_sel;
   logic [ADDR_W-1:0] index_base;
   logic [ADDR_W-1:0] phys_addr;
   logic indexed;
   modport gen
   (
      input file_addr,
      input access_bit,
      input ext_set_en,
      input bank_sel,
      input index_base,
      output phys_addr,
      output indexed
   );
   modport user
   (
      output file_addr,
      output access_bit,
      output ext_set_en,
      output bank_sel,
      output index_base,
      input phys_addr,
      input indexed
   );
endinterface
`default_nettype wire

/* File: hw/lacb_addr_gen.sv */
// resolves a file operand address to a physical data-memory address
`timescale 1ns/10ps
`default_nettype none
module lacb_addr_gen
   import lacb_pkg::*;
(
   lacb_addr_if.gen ai
);
   logic [ADDR_W-1:0] offset_sum;

   // indexed literal offset: base plus the literal, wraps inside the space
   assign offset_sum = ai.index_base + {{BANK_W{1'b0}}, ai.file_addr};

   always_comb
   begin
      ai.indexed = 1'b0;
      if (ai.access_bit == ACCESS_BANKED)
      begin
         ai.phys_addr = {ai.bank_sel, ai.file_addr};
      end
      else if (ai.ext_set_en && (ai.file_addr <= INDEXED_MAX))
      begin
         ai.indexed = 1'b1;
         ai.phys_addr = offset_sum;
      end
      else if (ai.file_addr < ACCESS_SPLIT)
      begin
         ai.phys_addr = {ACCESS_LO_BANK, ai.file_addr};
      end
      else
      begin
         ai.phys_addr = {ACCESS_HI_BANK, ai.file_addr};
      end
   end
endmodule
`default_nettype wire

/* File: hw/lacb_exec.sv */
// decode and execute for immediate AND, file-register AND and carry branch
// Notes on behaviour
// - mask_immediate ANDs accumulator with literal into accumulator, sets N and Z, one cycle.
// - mask_file_register ANDs accumulator with file register, sets only N and Z, one cycle.
// - destination bit 0 writes accumulator, 1 writes back to the file register.
// - access bit 0 picks the fixed access bank, 1 uses bank_select_register.
// - access 0, extended set on and address at most 5Fh use indexed offset.
// - carry_branch loads PC plus 2 plus twice signed offset when carry is set.
`timescale 1ns/10ps
`default_nettype none
module lacb_exec
   import lacb_pkg::*;
#(
   parameter int unsigned PC_W = 21
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire logic [INSTR_W-1:0] instr_word,
   output logic instr_ready,
   input wire logic carry_flag,
   input wire logic ext_set_en,
   input wire logic [BANK_W-1:0] bank_select_register,
   input wire logic [ADDR_W-1:0] index_base,
   output logic [ADDR_W-1:0] file_rd_addr,
   input wire logic [DATA_W-1:0] file_rd_data,
   output logic file_wr_en_ff,
   output logic [ADDR_W-1:0] file_wr_addr_ff,
   output logic [DATA_W-1:0] file_wr_data_ff,
   output logic [DATA_W-1:0] acc_ff,
   output logic neg_flag_ff,
   output logic zero_flag_ff,
   output logic [PC_W-1:0] pc_ff,
   output logic pc_wr_ff,
   output logic indexed_ff,
   output logic unknown_ff
);
   if (PC_W < 9 || PC_W > 32)
   begin
      $error("PC_W must lie between 9 and 32");
   end

   lacb_state_t state_ff;
   logic [3:0] opc_hi;
   logic [3:0] opc_mid;
   logic [7:0] low_byte;
   logic is_imm;
   logic is_reg;
   logic is_br;
   logic dest_bit;
   logic exec;
   logic br_taken;
   logic [DATA_W-1:0] imm_res;
   logic [DATA_W-1:0] reg_res;
   logic [PC_W-1:0] nxt_pc_seq;
   logic [PC_W-1:0] nxt_pc_br;
   logic [PC_W-1:0] br_disp;
   lacb_addr_if ai ();

   assign opc_hi = instr_word[OPC_HI_POS +: 4];
   assign opc_mid = instr_word[OPC_MID_POS +: 4];
   assign low_byte = instr_word[DATA_W-1:0];
   assign dest_bit = instr_word[DEST_POS];
   assign is_imm = (opc_hi == OPC_IMM_HI) && (opc_mid == OPC_IMM_MID);
   assign is_reg = (opc_hi == OPC_REG_HI) && (opc_mid[3:2] == OPC_REG_MID);
   assign is_br = (opc_hi == OPC_BR_HI) && (opc_mid == OPC_BR_MID);
   assign instr_ready = (state_ff == ST_EXEC);
   assign exec = instr_valid && instr_ready;
   assign br_taken = exec && is_br && carry_flag;

   assign imm_res = acc_ff & low_byte;
   assign reg_res = acc_ff & file_rd_data;

   // offset is a word count: sign extend, then double
   assign br_disp = {{(PC_W-DATA_W){low_byte[DATA_W-1]}}, low_byte} << 1;
   assign nxt_pc_seq = pc_ff + PC_W'(PC_STEP);
   assign nxt_pc_br = nxt_pc_seq + br_disp;

   assign ai.file_addr = low_byte;
   assign ai.access_bit = instr_word[ACCESS_POS];
   assign ai.ext_set_en = ext_set_en;
   assign ai.bank_sel = bank_select_register;
   assign ai.index_base = index_base;
   assign file_rd_addr = ai.phys_addr;

   lacb_addr_gen u_addr_gen
   (
      .ai(ai.gen)
   );

   // taken branch holds an idle cycle
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= ST_EXEC;
      end
      else if (br_taken)
      begin
         state_ff <= ST_IDLE;
      end
      else
      begin
         state_ff <= ST_EXEC;
      end
   end

   // accumulator and the two flags
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_ff <= ACC_RST;
         neg_flag_ff <= FLAG_RST;
         zero_flag_ff <= FLAG_RST;
      end
      else if (exec && is_imm)
      begin
         acc_ff <= imm_res;
         neg_flag_ff <= imm_res[DATA_W-1];
         zero_flag_ff <= (imm_res == '0);
      end
      else if (exec && is_reg)
      begin
         if (dest_bit == DEST_ACC)
         begin
            acc_ff <= reg_res;
         end
         neg_flag_ff <= reg_res[DATA_W-1];
         zero_flag_ff <= (reg_res == '0);
      end
   end

   // file register write-back
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         file_wr_en_ff <= 1'b0;
         file_wr_addr_ff <= '0;
         file_wr_data_ff <= '0;
         indexed_ff <= 1'b0;
      end
      else
      begin
         file_wr_en_ff <= exec && is_reg && (dest_bit == DEST_FILE);
         indexed_ff <= exec && is_reg && ai.indexed;
         if (exec && is_reg)
         begin
            file_wr_addr_ff <= ai.phys_addr;
            file_wr_data_ff <= reg_res;
         end
      end
   end

   // program counter; pc_wr_ff marks a branch load
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pc_ff <= '0;
         pc_wr_ff <= 1'b0;
         unknown_ff <= 1'b0;
      end
      else
      begin
         pc_wr_ff <= br_taken;
         unknown_ff <= exec && !(is_imm || is_reg || is_br);
         if (br_taken)
         begin
            pc_ff <= nxt_pc_br;
         end
         else if (exec)
         begin
            pc_ff <= nxt_pc_seq;
         end
      end
   end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   imm_and_result_a: assert property (exec && is_imm |=> acc_ff == $past(imm_res))
      else $error("immediate AND result wrong");
   imm_flags_a: assert property (exec && is_imm |=>
      zero_flag_ff == (acc_ff == 8'h00) && neg_flag_ff == acc_ff[7])
      else $error("immediate AND flags wrong");
   reg_and_flags_a: assert property (exec && is_reg |=>
      zero_flag_ff == ($past(reg_res) == 8'h00) && neg_flag_ff == $past(reg_res[7]))
      else $error("file AND flags wrong");
   reg_dest_file_a: assert property (exec && is_reg && dest_bit |=>
      file_wr_en_ff && file_wr_data_ff == $past(reg_res) && $stable(acc_ff))
      else $error("file destination not written");
   reg_dest_acc_a: assert property (exec && is_reg && !dest_bit |=>
      !file_wr_en_ff && acc_ff == $past(reg_res))
      else $error("accumulator destination not written");
   bank_select_a: assert property (exec && is_reg && instr_word[8] |->
      file_rd_addr == {bank_select_register, low_byte})
      else $error("banked address wrong");
   indexed_mode_a: assert property (exec && is_reg |=>
      indexed_ff == ($past(!instr_word[8] && ext_set_en) && $past(low_byte) <= 8'h5f))
      else $error("indexed mode decision wrong");
   branch_target_a: assert property (br_taken |=>
      pc_ff == PC_W'($past(pc_ff) + PC_STEP + PC_W'(2 * $signed($past(low_byte)))))
      else $error("branch target wrong");
   branch_flags_a: assert property (exec && is_br |=>
      $stable(neg_flag_ff) && $stable(zero_flag_ff) && $stable(acc_ff))
      else $error("branch changed flags");
   branch_idle_a: assert property (br_taken |=> !instr_ready ##1 instr_ready)
      else $error("taken branch idle cycle wrong");
   no_jump_a: assert property (exec && is_br && !carry_flag |=>
      !pc_wr_ff && instr_ready && pc_ff == PC_W'($past(pc_ff) + PC_STEP))
      else $error("untaken branch wrong");

   taken_c: cover property (br_taken ##2 exec && is_imm);
   not_taken_c: cover property (exec && is_br && !carry_flag);
   indexed_c: cover property (exec && is_reg && ai.indexed && dest_bit);
   banked_c: cover property (exec && is_reg && instr_word[8] && !dest_bit);
   refused_c: cover property (instr_valid && !instr_ready);
endmodule
`default_nettype wire

/* File: sim/tb_logic_and_carry_branch_exec.sv */
// self-checking bench for the logic-and-carry-branch execute block
`timescale 1ns/10ps
`default_nettype none
module tb_logic_and_carry_branch_exec;
   import lacb_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [INSTR_W-1:0] instr_word = '0;
   logic carry_flag = 1'b0;
   logic ext_set_en = 1'b0;
   logic [BANK_W-1:0] bank_select_register = 4'h5;
   logic [ADDR_W-1:0] index_base = 12'hff0;
   logic instr_ready;
   logic [ADDR_W-1:0] file_rd_addr;
   logic [DATA_W-1:0] file_rd_data;
   logic file_wr_en_ff;
   logic [ADDR_W-1:0] file_wr_addr_ff;
   logic [DATA_W-1:0] file_wr_data_ff;
   logic [DATA_W-1:0] acc_ff;
   logic neg_flag_ff;
   logic zero_flag_ff;
   logic [20:0] pc_ff;
   logic pc_wr_ff;
   logic indexed_ff;
   logic unknown_ff;
   int fails = 0;
   int compares = 0;
   logic [20:0] exp_pc;
   logic [ADDR_W-1:0] rd_seen;
   logic [7:0] exp_acc;
   logic [7:0] exp_res;
   // operand cases: file address, access bit, extended set, indexed, resolved address
   logic [7:0] fa_t [5] = '{8'h34, 8'h20, 8'h80, 8'h5f, 8'h60};
   logic ac_t [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   logic ex_t [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   logic ix_t [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   logic [11:0] ad_t [5] = '{12'h534, 12'h020, 12'hf80, 12'h04f, 12'hf60};
   logic cy_t [3] = '{1'b1, 1'b0, 1'b1};
   logic [7:0] n_t [3] = '{8'h80, 8'h7f, 8'h7f};

   always #50 sys_clk = ~sys_clk;

   // data memory answers in the same cycle as the address
   assign file_rd_data = file_rd_addr[7:0] ^ 8'hda;

   lacb_exec u_lacb_exec
   (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .instr_ready(instr_ready),
      .carry_flag(carry_flag),
      .ext_set_en(ext_set_en),
      .bank_select_register(bank_select_register),
      .index_base(index_base),
      .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data),
      .file_wr_en_ff(file_wr_en_ff),
      .file_wr_addr_ff(file_wr_addr_ff),
      .file_wr_data_ff(file_wr_data_ff),
      .acc_ff(acc_ff),
      .neg_flag_ff(neg_flag_ff),
      .zero_flag_ff(zero_flag_ff),
      .pc_ff(pc_ff),
      .pc_wr_ff(pc_wr_ff),
      .indexed_ff(indexed_ff),
      .unknown_ff(unknown_ff)
   );

   task close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   // one word taken at the next edge; tv/tw are driven in the cycle after
   task step(input logic [15:0] w, input logic tv, input logic [15:0] tw);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      #1 rd_seen = file_rd_addr;
      @(posedge sys_clk);
      instr_valid <= tv;
      instr_word <= tw;
      #1;
   endtask

   task t_imm;
      chk(acc_ff, ACC_RST, "acc after reset");
      chk(pc_ff, 0, "pc after reset");
      chk({neg_flag_ff, zero_flag_ff, instr_ready}, 3'b001, "outputs after reset");
      // two literals back to back; the second is taken one edge later
      step(16'h0ba3, 1'b1, 16'h0bd7);
      exp_acc = ACC_RST & 8'ha3;
      exp_pc = exp_pc + 2;
      chk(acc_ff, exp_acc, "immediate result");
      chk({neg_flag_ff, zero_flag_ff}, {exp_acc[7], exp_acc == 8'h00}, "immediate flags");
      chk(pc_ff, exp_pc, "immediate pc");
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      exp_acc = exp_acc & 8'hd7;
      exp_pc = exp_pc + 2;
      chk(acc_ff, exp_acc, "second immediate result");
      chk({neg_flag_ff, zero_flag_ff}, {exp_acc[7], exp_acc == 8'h00}, "second flags");
      chk(pc_ff, exp_pc, "second immediate pc");
      $display("test t_imm done");
   endtask

   task t_reg;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge sys_clk);
         ext_set_en <= ex_t[i];
         step({4'h1, 2'h1, i[0], ac_t[i], fa_t[i]}, 1'b0, 16'h0000);
         exp_pc = exp_pc + 2;
         exp_res = exp_acc & (ad_t[i][7:0] ^ 8'hda);
         if (!i[0])
            exp_acc = exp_res;
         chk(rd_seen, ad_t[i], "operand address");
         chk(indexed_ff, ix_t[i], "indexed mode");
         chk(file_wr_en_ff, i[0], "write back");
         if (i[0])
            chk({file_wr_addr_ff, file_wr_data_ff}, {ad_t[i], exp_res}, "write target");
         chk({neg_flag_ff, zero_flag_ff, acc_ff}, {exp_res[7], exp_res == 8'h00, exp_acc},
            "register flags");
         chk(pc_ff, exp_pc, "register pc");
      end
      $display("test t_reg done");
   endtask

   task t_branch;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         carry_flag <= cy_t[i];
         step({8'he2, n_t[i]}, 1'b1, 16'hffff);
         if (cy_t[i])
            exp_pc = exp_pc + 2 + {{12{n_t[i][7]}}, n_t[i], 1'b0};
         else
            exp_pc = exp_pc + 2;
         chk(pc_ff, exp_pc, "branch pc");
         chk({pc_wr_ff, instr_ready}, {cy_t[i], ~cy_t[i]}, "branch pulse and ready");
         chk({neg_flag_ff, zero_flag_ff, acc_ff}, {exp_res[7], exp_res == 8'h00, exp_acc},
            "flags kept");
         @(posedge sys_clk);
         instr_valid <= 1'b0;
         #1;
         // the trailing word is refused after a taken branch, taken otherwise
         if (!cy_t[i])
            exp_pc = exp_pc + 2;
         chk({unknown_ff, instr_ready}, {~cy_t[i], 1'b1}, "idle cycle");
         chk(pc_ff, exp_pc, "pc after idle");
      end
      $display("test t_branch done");
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1;
      exp_pc = '0;
      t_imm();
      t_reg();
      t_branch();
      close_out();
   end

   initial
   begin
      repeat (2000) @(posedge sys_clk);
      fails++;
      $display("CHECK FAILED at %0t: run limit reached", $time);
      close_out();
   end
endmodule
`default_nettype wire
